/* hdl/ptmr_core.sv */
// Periodic timer with compare A and period comparators, four modes and
// an APB register file.
// Assumes pclk at 50 MHz, external_trigger_pin synchronous to pclk.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Clear-select 1: compare A match clears counter
// - Compare mode pin changes only on A match
// - Enable rising edge restores initial pin level
// - Clear-select 1 never raises period flag outside PWM
// - Mode 11 counts like compare, pin released
// - PWM period from period value, 0 means 1024
// - Duty at or above period holds active
// - PWM raises A and period flags separately
// - Level bit picks active level, polarity inverts
// - Functions 00/01 force pin, counting continues
// - PWM ignores clear-select, period always clears
// - Single pulse: enable rise starts pulse
// - Trigger pin edge sets enable in pulse mode
// - Pulse ends on clear or A match
// - Single pulse A match raises A flag
// - Single pulse counter zeroed only on enable rise
// - 10-bit counter, A value 0 overflows silently
// - Compare mode pin high, low or toggle
module ptmr_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptmr_pkg::APB_AW-1:0] paddr,
  input wire logic [ptmr_pkg::APB_DW-1:0] pwdata,
  output logic [ptmr_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire logic external_trigger_pin,
  output logic timer_pin,
  output logic timer_pin_oe
);
  import ptmr_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic en; // counter_enable
    logic [CKSEL_W-1:0] cksel; // Timer clock select
    logic [1:0] mode; // mode_select_hi/lo
    logic [1:0] ofn; // output_function_hi/lo
    logic olc; // output_level_control
    logic pol; // output_polarity
    logic ccl; // counter_clear_select
    logic [CNT_W-1:0] cnt; // Counter
    logic [CNT_W-1:0] cmpa; // compare_a_value
    logic [CNT_W-1:0] per; // period_value
    logic fa; // compare_a_flag
    logic fp; // period_match_flag
    logic lvl; // Compare mode pin level before polarity
    logic pin; // Pin level as driven
    logic oe; // Pin drive enable
    logic trig_q; // Trigger pin one cycle ago
    logic rdy; // APB answer pending
    logic [APB_DW-1:0] rdata; // Captured read word
  } ptmr_state_t;

  ptmr_state_t st_ff; // Registered state
  ptmr_state_t nxt_st_ff; // Its next value

  ptmr_tick_if tk (); // Prescaler link

  logic acc_req; // Access phase in progress
  logic done; // Transfer completes this edge
  logic unmapped; // Address decodes to nothing
  logic wr_go; // Register write this edge
  logic [APB_DW-1:0] rd_word; // Read mux
  logic trig_edge; // Rising edge on trigger pin
  logic sp_mode; // Single pulse mode now
  logic en_req; // Enable after software and trigger
  logic en_rise; // Enable goes low to high
  logic [CNT_W-1:0] cnt_inc; // Counter plus one, wraps at 1024
  logic a_eq; // Next count meets compare A
  logic p_end; // Period reached
  logic a_hit; // Compare A match event
  logic p_hit; // Period match event
  logic duty_on; // PWM active phase
  logic lv; // Pin level before polarity

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  assign tk.sel = st_ff.cksel;

  ptmr_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk.gen)
  );

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // One wait state so that read data can come from a flip-flop
  assign acc_req = psel & penable;
  assign done = acc_req & st_ff.rdy;
  assign unmapped = !(paddr == ADDR_CTRL0 || paddr == ADDR_CTRL1 ||
                      paddr == ADDR_COUNT || paddr == ADDR_CMPA ||
                      paddr == ADDR_PERIOD || paddr == ADDR_STATUS);
  assign wr_go = done & pwrite & ~unmapped;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.rdy & unmapped;
  assign prdata = st_ff.rdata;

  // Read mux, unused upper bits read as zero
  always_comb begin
    rd_word = RDATA_ZERO;
    case (paddr)
      ADDR_CTRL0: begin
        rd_word[CTRL0_EN_BIT] = st_ff.en;
        rd_word[CTRL0_CKSEL_LSB +: CKSEL_W] = st_ff.cksel;
      end
      ADDR_CTRL1: begin
        rd_word[CTRL1_CCL_BIT] = st_ff.ccl;
        rd_word[CTRL1_POL_BIT] = st_ff.pol;
        rd_word[CTRL1_OLC_BIT] = st_ff.olc;
        rd_word[CTRL1_OFN_LSB +: 2] = st_ff.ofn;
        rd_word[CTRL1_MODE_LSB +: 2] = st_ff.mode;
      end
      ADDR_COUNT: rd_word[CNT_W-1:0] = st_ff.cnt;
      ADDR_CMPA: rd_word[CNT_W-1:0] = st_ff.cmpa;
      ADDR_PERIOD: rd_word[CNT_W-1:0] = st_ff.per;
      ADDR_STATUS: begin
        rd_word[STATUS_FA_BIT] = st_ff.fa;
        rd_word[STATUS_FP_BIT] = st_ff.fp;
      end
      default: rd_word = RDATA_ZERO;
    endcase
  end

  // ----------------------------------------------------------------------
  // Event terms
  // ----------------------------------------------------------------------
  assign sp_mode = (st_ff.mode == MODE_PWM) && (st_ff.ofn == OFN_TOGGLE);
  assign trig_edge = external_trigger_pin & ~st_ff.trig_q;
  assign cnt_inc = st_ff.cnt + CNT_W'(1);
  // A value of zero never matches, so the counter just rolls over
  assign a_eq = (st_ff.cmpa != CNT_ZERO) && (cnt_inc == st_ff.cmpa);
  // Period zero means a full 1024-count cycle ending at the overflow
  assign p_end = (st_ff.per != CNT_ZERO) ? (cnt_inc == st_ff.per)
                                         : (st_ff.cnt == CNT_MAX);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st_ff = st_ff;
    a_hit = 1'b0;
    p_hit = 1'b0;
    duty_on = 1'b0;
    lv = 1'b0;
    en_req = st_ff.en;
    en_rise = 1'b0;

    // APB answer one cycle into the access phase
    nxt_st_ff.rdy = acc_req & ~st_ff.rdy;
    if (acc_req && !st_ff.rdy) begin
      nxt_st_ff.rdata = rd_word;
    end
    nxt_st_ff.trig_q = external_trigger_pin;

    // Register writes
    if (wr_go) begin
      case (paddr)
        ADDR_CTRL0: begin
          nxt_st_ff.en = pwdata[CTRL0_EN_BIT];
          nxt_st_ff.cksel = pwdata[CTRL0_CKSEL_LSB +: CKSEL_W];
        end
        ADDR_CTRL1: begin
          nxt_st_ff.ccl = pwdata[CTRL1_CCL_BIT];
          nxt_st_ff.pol = pwdata[CTRL1_POL_BIT];
          nxt_st_ff.olc = pwdata[CTRL1_OLC_BIT];
          nxt_st_ff.ofn = pwdata[CTRL1_OFN_LSB +: 2];
          nxt_st_ff.mode = pwdata[CTRL1_MODE_LSB +: 2];
        end
        ADDR_CMPA: nxt_st_ff.cmpa = pwdata[CNT_W-1:0];
        ADDR_PERIOD: nxt_st_ff.per = pwdata[CNT_W-1:0];
        default: nxt_st_ff.cmpa = nxt_st_ff.cmpa;
      endcase
    end

    // Trigger pin starts a stopped pulse, ignored while one is running
    if (sp_mode && trig_edge && !st_ff.en) begin
      nxt_st_ff.en = 1'b1;
    end
    en_req = nxt_st_ff.en;
    en_rise = en_req & ~st_ff.en;

    if (en_rise) begin
      // Restart from zero and restore the initial pin level
      nxt_st_ff.cnt = CNT_ZERO;
      nxt_st_ff.lvl = nxt_st_ff.olc;
    end else if (st_ff.en && tk.tick) begin
      nxt_st_ff.cnt = cnt_inc;
      if (sp_mode) begin
        // Compare A ends a running pulse, as does a software clear; period and clear-select unused
        if (a_eq) begin
          a_hit = 1'b1;
          nxt_st_ff.en = 1'b0;
        end
      end else if (st_ff.mode == MODE_PWM || !st_ff.ccl) begin
        // PWM always clears on period, whatever clear-select says
        if (p_end) begin
          nxt_st_ff.cnt = CNT_ZERO;
          p_hit = 1'b1;
        end
        if (a_eq) begin
          a_hit = 1'b1;
        end
      end else begin
        // Clear on compare A; the period comparator stays silent
        if (a_eq) begin
          nxt_st_ff.cnt = CNT_ZERO;
          a_hit = 1'b1;
        end
      end
    end

    // Compare mode pin moves only on an A match
    if (a_hit && st_ff.mode != MODE_PWM) begin
      case (st_ff.ofn)
        OFN_LOW: nxt_st_ff.lvl = 1'b0;
        OFN_HIGH: nxt_st_ff.lvl = 1'b1;
        OFN_TOGGLE: nxt_st_ff.lvl = ~st_ff.lvl;
        default: nxt_st_ff.lvl = st_ff.lvl;
      endcase
    end

    // Sticky flags: write one clears, a same-cycle event wins
    if (wr_go && paddr == ADDR_STATUS) begin
      nxt_st_ff.fa = st_ff.fa & ~pwdata[STATUS_FA_BIT];
      nxt_st_ff.fp = st_ff.fp & ~pwdata[STATUS_FP_BIT];
    end
    nxt_st_ff.fa = nxt_st_ff.fa | a_hit;
    nxt_st_ff.fp = nxt_st_ff.fp | p_hit;

    // Pin level from the next state so the pin flop tracks it exactly
    duty_on = ((nxt_st_ff.per != CNT_ZERO) &&
               (nxt_st_ff.cmpa >= nxt_st_ff.per)) ||
              (nxt_st_ff.cnt < nxt_st_ff.cmpa);
    case (nxt_st_ff.mode)
      MODE_CMP: lv = nxt_st_ff.lvl;
      MODE_PWM: begin
        case (nxt_st_ff.ofn)
          OFN_NONE: lv = 1'b0;
          OFN_LOW: lv = 1'b1;
          OFN_HIGH: lv = duty_on ? nxt_st_ff.olc : ~nxt_st_ff.olc;
          default: lv = nxt_st_ff.en ? nxt_st_ff.olc : ~nxt_st_ff.olc;
        endcase
      end
      default: lv = 1'b0;
    endcase
    // Timer/counter mode and the unused code leave the pin free
    nxt_st_ff.oe = (nxt_st_ff.mode == MODE_CMP) ||
                   (nxt_st_ff.mode == MODE_PWM);
    nxt_st_ff.pin = (lv ^ nxt_st_ff.pol) & nxt_st_ff.oe;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st_ff;
    end
  end

  assign timer_pin = st_ff.pin;
  assign timer_pin_oe = st_ff.oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic ctrl1_wr; // Configuration rewrite this cycle
  assign ctrl1_wr = wr_go && (paddr == ADDR_CTRL1);

  clear_on_a_a: assert property (
    (st_ff.mode == MODE_CMP && st_ff.ccl && st_ff.en && tk.tick && a_eq)
    |=> (st_ff.cnt == CNT_ZERO) && st_ff.fa)
    else $error("Counter not cleared on compare A match");

  pin_only_a_a: assert property (
    (st_ff.mode == MODE_CMP && !a_hit && !en_rise && !ctrl1_wr)
    |=> $stable(timer_pin))
    else $error("Compare pin moved without an A match");

  init_level_a: assert property (
    (en_rise && nxt_st_ff.mode == MODE_CMP)
    |=> timer_pin == (st_ff.olc ^ st_ff.pol))
    else $error("Pin not at initial level after enable");

  no_p_flag_a: assert property (
    (st_ff.ccl && !st_ff.fp && st_ff.mode != MODE_PWM && !ctrl1_wr)
    |=> !st_ff.fp)
    else $error("Period flag raised with clear-select set");

  tmr_release_a: assert property (
    (st_ff.mode == MODE_TMR) |-> !timer_pin_oe && !timer_pin)
    else $error("Pin driven in timer/counter mode");

  full_duty_a: assert property (
    (st_ff.mode == MODE_PWM && st_ff.ofn == OFN_HIGH &&
     st_ff.per != CNT_ZERO && st_ff.cmpa >= st_ff.per)
    |-> timer_pin == (st_ff.olc ^ st_ff.pol))
    else $error("Full duty not held active");

  pulse_stop_a: assert property (
    (sp_mode && st_ff.en && tk.tick && a_eq)
    |=> !st_ff.en && st_ff.fa && timer_pin == (~st_ff.olc ^ st_ff.pol))
    else $error("Pulse not ended by compare A");

  trig_start_a: assert property (
    (sp_mode && trig_edge && !st_ff.en && !ctrl1_wr)
    |=> st_ff.en && st_ff.cnt == CNT_ZERO)
    else $error("Trigger edge did not start pulse");

  flag_hold_a: assert property (
    (st_ff.fa && !(wr_go && paddr == ADDR_STATUS)) |=> st_ff.fa)
    else $error("A flag lost without a clear");

  count_hold_a: assert property (
    (!st_ff.en && !en_rise) |=> $stable(st_ff.cnt))
    else $error("Counter moved while disabled");

  apb_answer_a: assert property (
    (acc_req && !pready) |=> pready)
    else $error("APB answer not one wait state");

  pwm_period_c: cover property (
    st_ff.mode == MODE_PWM && p_hit ##1 st_ff.fp);
  pulse_done_c: cover property (
    sp_mode && st_ff.en ##[1:300] !st_ff.en);
  cmp_toggle_c: cover property (
    st_ff.mode == MODE_CMP && st_ff.ofn == OFN_TOGGLE && a_hit);
endmodule
`default_nettype wire

/* hdl/ptmr_pkg.sv */
// Shared constants of the periodic timer: register map, field positions,
// reset values, mode and output-function codes.
// Assumes a 32-bit APB slave port with byte addresses in the low 8 bits.
package ptmr_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int CNT_W = 10;
  localparam int CKSEL_W = 3;
  localparam int DIV_W = 7;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CMPA = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL0_EN_BIT = 0;
  localparam int CTRL0_CKSEL_LSB = 1;
  localparam int CTRL1_CCL_BIT = 0;
  localparam int CTRL1_POL_BIT = 2;
  localparam int CTRL1_OLC_BIT = 3;
  localparam int CTRL1_OFN_LSB = 4;
  localparam int CTRL1_MODE_LSB = 6;
  localparam int STATUS_FA_BIT = 0;
  localparam int STATUS_FP_BIT = 1;

  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] OFN_NONE = 2'h0;
  localparam logic [1:0] OFN_LOW = 2'h1;
  localparam logic [1:0] OFN_HIGH = 2'h2;
  localparam logic [1:0] OFN_TOGGLE = 2'h3;
  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

/* hdl/ptmr_tick_if.sv */
// Carries the timer clock select and the resulting tick between the
// timer core and its prescaler.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface ptmr_tick_if;
  logic [2:0] sel; // Divide by two to the power sel
  logic tick; // One-cycle pulse per timer clock

  // Prescaler end
  modport gen (input sel, output tick);
  // Timer core end
  modport user (output sel, input tick);
endinterface
`default_nettype wire

/* hdl/ptmr_tick_gen.sv */
// Prescaler that derives the timer clock tick from pclk.
// Assumes sel is steady for the life of a count; a change just rephases.
`timescale 1ns/1ps
`default_nettype none
module ptmr_tick_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Select in, tick out
  ptmr_tick_if.gen tk
);
  import ptmr_pkg::*;

  // Whole state of the prescaler
  typedef struct packed {
    logic [DIV_W-1:0] div;
  } ptmr_div_t;

  ptmr_div_t div_ff; // Free-running divider
  ptmr_div_t nxt_div_ff;
  logic [DIV_W-1:0] mask; // Low bits that must all be ones

  // Mask of the low sel bits; sel 0 gives a tick every cycle
  assign mask = DIV_W'((8'h01 << tk.sel) - 8'h01);
  assign tk.tick = (div_ff.div & mask) == mask;

  // Next divider value
  always_comb begin
    nxt_div_ff = div_ff;
    nxt_div_ff.div = div_ff.div + DIV_W'(1);
  end

  // Divider register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div_ff;
    end
  end
endmodule
`default_nettype wire

/* sim/ptmr_far_model.sv */
// Far-side model: load on the timer pin and the trigger source.
// Assumes one pclk domain; the trigger is made synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module ptmr_far_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench request for one trigger pulse
  input wire logic fire,
  // Pins
  input wire logic timer_pin,
  input wire logic timer_pin_oe,
  output logic external_trigger_pin,
  output logic pin_w
);
  logic float_ff; // Level seen on the undriven pin

  // ------------------------------------------------------------------
  // Trigger and float pattern
  // ------------------------------------------------------------------
  // One rising edge on the trigger per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_trigger_pin <= 1'b0;
      float_ff <= 1'b0;
    end else begin
      external_trigger_pin <= fire;
      float_ff <= ~float_ff;
    end
  end
  // No pull on the pin, so a released pin wanders instead of holding
  assign pin_w = timer_pin_oe ? timer_pin : float_ff;
endmodule
`default_nettype wire

/* sim/periodic_timer_modes_tb.sv */
// Testbench of the periodic timer: APB tasks and mode scenarios.
// Assumes the far-side model for pin load and trigger.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_modes_tb;
  import ptmr_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, fire;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, trig, timer_pin, timer_pin_oe, pin_w;
  int errors, samples_checked, cycles, hi, lo;

  ptmr_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_pin(trig), .timer_pin(timer_pin),
    .timer_pin_oe(timer_pin_oe));
  ptmr_far_model u_far (.pclk(pclk), .presetn(presetn), .fire(fire),
    .timer_pin(timer_pin), .timer_pin_oe(timer_pin_oe),
    .external_trigger_pin(trig), .pin_w(pin_w));

  // ------------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Run needs about 5000 cycles; well past that means a hang
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      end_sim();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic end_sim;
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  // No wait limit of its own: a slave that never answers trips the guard
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // Stop first so the output function only changes while stopped
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a,
    input logic [9:0] p, input logic [2:0] s, input logic en);
    wr(ADDR_CTRL0, {28'h0, s, 1'b0});
    wr(ADDR_CTRL1, {24'h0, c1});
    wr(ADDR_CMPA, {22'h0, a});
    wr(ADDR_PERIOD, {22'h0, p});
    wr(ADDR_STATUS, 32'h0000_0003);
    wr(ADDR_CTRL0, {28'h0, s, en});
  endtask
  // High and low widths of the next pulse on the pin, in cycles
  task automatic meas(output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    @(negedge pclk);
    while (pin_w !== 1'b0 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    while (pin_w !== 1'b1 && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    while (pin_w === 1'b1 && h < 1100) begin
      @(negedge pclk);
      h++;
    end
    while (pin_w === 1'b0 && l < 1100) begin
      @(negedge pclk);
      l++;
    end
  endtask
  // Pin must hold one level for 20 cycles after settling
  task automatic steady(input logic x);
    int n;
    n = 0;
    repeat (12) @(negedge pclk);
    repeat (20) begin
      @(negedge pclk);
      if (pin_w === x) n++;
    end
    chk(n, 20);
  endtask
  task automatic pw(input logic [7:0] c1, input logic [9:0] a,
    input logic [9:0] p, input logic [2:0] s, input int xh, input int xl);
    cfg(c1, a, p, s, 1'b1);
    meas(hi, lo);
    chk(hi, xh);
    chk(lo, xl);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, fire} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // State clears to zero, so the drive enable returns one edge later
    repeat (2) @(negedge pclk);
    chk({30'h0, timer_pin, timer_pin_oe}, 32'h0000_0001);
    // Reset values, unmapped and misaligned places
    rchk(ADDR_CTRL0, 32'h0000_0000, 1'b0);
    rchk(ADDR_CTRL1, 32'h0000_0000, 1'b0);
    rchk(ADDR_COUNT, 32'h0000_0000, 1'b0);
    rchk(ADDR_CMPA, 32'h0000_0000, 1'b0);
    rchk(ADDR_STATUS, 32'h0000_0000, 1'b0);
    rchk(8'h18, 32'h0000_0000, 1'b1);
    rchk(8'h02, 32'h0000_0000, 1'b1);
    wr(ADDR_PERIOD, 32'hFFFF_FFFF);
    rchk(ADDR_PERIOD, 32'h0000_03FF, 1'b0);
    // Compare mode, clear on A: toggle, no change, high and low
    pw(8'h31, 10'h005, 10'h002, 3'h0, 5, 5);
    rchk(ADDR_STATUS, 32'h0000_0001, 1'b0);
    rchk(ADDR_STATUS, 32'h0000_0001, 1'b0);
    cfg(8'h39, 10'h005, 10'h002, 3'h0, 1'b1);
    @(negedge pclk);
    chk({31'h0, pin_w}, 32'h0000_0001);
    cfg(8'h09, 10'h005, 10'h002, 3'h0, 1'b1);
    steady(1'b1);
    cfg(8'h21, 10'h005, 10'h002, 3'h0, 1'b1);
    steady(1'b1);
    cfg(8'h19, 10'h005, 10'h002, 3'h0, 1'b1);
    steady(1'b0);
    // Period match clears but leaves the pin alone
    cfg(8'h30, 10'h007, 10'h003, 3'h0, 1'b1);
    steady(1'b0);
    rchk(ADDR_STATUS, 32'h0000_0002, 1'b0);
    // A value zero stays quiet; period zero clears at the 10-bit limit and sets the period flag
    cfg(8'h30, 10'h000, 10'h000, 3'h0, 1'b1);
    repeat (1100) @(posedge pclk);
    rchk(ADDR_STATUS, 32'h0000_0002, 1'b0);
    steady(1'b0);
    // Timer mode releases the pin but keeps flags
    cfg(8'hF1, 10'h005, 10'h002, 3'h0, 1'b1);
    @(negedge pclk);
    chk({31'h0, timer_pin_oe}, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    rchk(ADDR_STATUS, 32'h0000_0001, 1'b0);
    // PWM widths, polarity, prescaler and clear-select
    pw(8'hA8, 10'h001, 10'h004, 3'h0, 1, 3);
    rchk(ADDR_STATUS, 32'h0000_0003, 1'b0);
    rchk(ADDR_CTRL1, 32'h0000_00A8, 1'b0);
    pw(8'hA8, 10'h001, 10'h004, 3'h1, 2, 6);
    pw(8'hAC, 10'h001, 10'h004, 3'h0, 3, 1);
    pw(8'hA0, 10'h001, 10'h004, 3'h0, 3, 1);
    pw(8'hA4, 10'h001, 10'h004, 3'h0, 1, 3);
    pw(8'hA9, 10'h001, 10'h004, 3'h0, 1, 3);
    pw(8'hA8, 10'h200, 10'h000, 3'h0, 512, 512);
    cfg(8'hA8, 10'h006, 10'h004, 3'h0, 1'b1);
    steady(1'b1);
    cfg(8'h88, 10'h001, 10'h004, 3'h0, 1'b1);
    steady(1'b0);
    rchk(ADDR_STATUS, 32'h0000_0003, 1'b0);
    cfg(8'h98, 10'h001, 10'h004, 3'h0, 1'b1);
    steady(1'b1);
    // Single pulse from software, then from the trigger pin
    cfg(8'hB8, 10'h003, 10'h000, 3'h0, 1'b1);
    @(negedge pclk);
    chk({31'h0, pin_w}, 32'h0000_0001);
    repeat (5) @(negedge pclk);
    chk({31'h0, pin_w}, 32'h0000_0000);
    rchk(ADDR_CTRL0, 32'h0000_0000, 1'b0);
    rchk(ADDR_STATUS, 32'h0000_0001, 1'b0);
    rchk(ADDR_COUNT, 32'h0000_0003, 1'b0);
    wr(ADDR_STATUS, 32'h0000_0003);
    fork
      meas(hi, lo);
      begin
        repeat (3) @(posedge pclk);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
      end
    join
    chk(hi, 3);
    rchk(ADDR_STATUS, 32'h0000_0001, 1'b0);
    wr(ADDR_CMPA, 32'h0000_00C8);
    wr(ADDR_CTRL0, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, pin_w}, 32'h0000_0001);
    wr(ADDR_CTRL0, 32'h0000_0000);
    @(negedge pclk);
    chk({31'h0, pin_w}, 32'h0000_0000);
    end_sim();
  end
endmodule
`default_nettype wire
